// file: hdl/scb_config_bank.sv
// Setup configuration register bank with APB slave and active-setup decode
`timescale 1ns/100ps
`default_nettype none
`include "scb_consts.svh"
module scb_config_bank
  import scb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SCB_PADDR_W-1:0] paddr,
  input wire logic [`SCB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [`SCB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] active_setup,
  output logic output_coding_select,
  output logic ref_pos_buffer_enable,
  output logic ref_neg_buffer_enable,
  output logic input_pos_buffer_enable,
  output logic input_neg_buffer_enable,
  output logic open_wire_source_on,
  output logic open_wire_sink_on,
  output logic [1:0] reference_source_select,
  output logic ref_route_primary,
  output logic ref_route_second,
  output logic ref_route_supply
);
  // Top state and its next value
  scb_bank_s st;
  scb_bank_s next_st;

  // Stored value of every setup
  logic [`SCB_REG_W-1:0] setup_val [0:`SCB_NUM_SETUPS-1];
  // Per-setup write strobe
  logic [`SCB_NUM_SETUPS-1:0] wr_sel;
  // Word index of the bus address
  logic [9:0] word_idx;
  // Address lands on a setup register
  logic addr_hit;
  // Setup number addressed
  logic [2:0] addr_setup;
  // Setup chosen by the converter sequencer
  logic [`SCB_REG_W-1:0] sel_val;
  // Completing access cycle
  logic access_done;

  assign word_idx = paddr[`SCB_PADDR_W-1:2];
  assign addr_setup = paddr[4:2];
  assign sel_val = setup_val[active_setup];
  assign access_done = psel && penable && st.pready;

  // Address decode; misaligned or unmapped words answer with an error
  always_comb begin
    addr_hit = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      addr_hit = 1'b0;
    end else if (word_idx >= `SCB_SETUP0_IDX && word_idx <= `SCB_SETUP7_IDX) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Write strobes: only at the completing edge, only on a hit
  always_comb begin
    wr_sel = '0;
    if (access_done && pwrite && addr_hit && !st.pslverr) begin
      wr_sel[addr_setup] = 1'b1;
    end
  end

  // One register instance per setup, same layout for all
  genvar gi;
  generate
    for (gi = 0; gi < `SCB_NUM_SETUPS; gi = gi + 1) begin : g_setup
      scb_setup_reg u_setup (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .wr_en(wr_sel[gi]),
        .wr_strb(pstrb[1:0]),
        .wr_data(pwdata[`SCB_REG_W-1:0]),
        .value(setup_val[gi])
      );
    end
  endgenerate

  // Reference code to route; code 10 falls back to the primary pins
  function automatic scb_ref_e ref_decode(input logic [1:0] code);
    scb_ref_e r;
    case (code)
      `SCB_REF_CODE_PRIMARY: r = SCB_REF_PRIMARY;
      `SCB_REF_CODE_SECOND: r = SCB_REF_SECOND;
      `SCB_REF_CODE_SUPPLY: r = SCB_REF_SUPPLY;
      default: r = SCB_REF_PRIMARY;
    endcase
    return r;
  endfunction

  // Next state: bus answer plus decode of the active setup
  always_comb begin
    scb_ref_e route;
    route = ref_decode(sel_val[`SCB_REF_SEL_HI:`SCB_REF_SEL_LO]);
    next_st = st;
    if (clk_en) begin
      // Setup phase: answer is ready in the first access cycle
      if (psel && !penable && !st.pready) begin
        next_st.pready = 1'b1;
        next_st.pslverr = !addr_hit;
        if (addr_hit && !pwrite) begin
          next_st.prdata = {16'h0000, setup_val[addr_setup]};
        end else begin
          next_st.prdata = 32'h0000_0000;
        end
      end else if (access_done) begin
        // Transfer over; drop the answer
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
      end
      // Controls of the setup in use
      next_st.output_coding_select = sel_val[`SCB_BIT_CODING];
      next_st.ref_pos_buffer_enable = sel_val[`SCB_BIT_REF_POS];
      next_st.ref_neg_buffer_enable = sel_val[`SCB_BIT_REF_NEG];
      next_st.input_pos_buffer_enable = sel_val[`SCB_BIT_IN_POS];
      next_st.input_neg_buffer_enable = sel_val[`SCB_BIT_IN_NEG];
      // Source and sink always switch as a pair
      next_st.open_wire_source_on = sel_val[`SCB_BIT_OPEN_WIRE];
      next_st.open_wire_sink_on = sel_val[`SCB_BIT_OPEN_WIRE];
      next_st.reference_source_select = sel_val[`SCB_REF_SEL_HI:`SCB_REF_SEL_LO];
      // One-hot route drives the reference switches
      next_st.ref_route_primary = (route == SCB_REF_PRIMARY);
      next_st.ref_route_second = (route == SCB_REF_SECOND);
      next_st.ref_route_supply = (route == SCB_REF_SUPPLY);
    end
  end

  // State register; decode outputs start at the reset setup value
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000,
        output_coding_select: 1'b1,
        ref_pos_buffer_enable: 1'b0,
        ref_neg_buffer_enable: 1'b0,
        input_pos_buffer_enable: 1'b0,
        input_neg_buffer_enable: 1'b0,
        open_wire_source_on: 1'b0,
        open_wire_sink_on: 1'b0,
        reference_source_select: 2'h0,
        ref_route_primary: 1'b1,
        ref_route_second: 1'b0,
        ref_route_supply: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign output_coding_select = st.output_coding_select;
  assign ref_pos_buffer_enable = st.ref_pos_buffer_enable;
  assign ref_neg_buffer_enable = st.ref_neg_buffer_enable;
  assign input_pos_buffer_enable = st.input_pos_buffer_enable;
  assign input_neg_buffer_enable = st.input_neg_buffer_enable;
  assign open_wire_source_on = st.open_wire_source_on;
  assign open_wire_sink_on = st.open_wire_sink_on;
  assign reference_source_select = st.reference_source_select;
  assign ref_route_primary = st.ref_route_primary;
  assign ref_route_second = st.ref_route_second;
  assign ref_route_supply = st.ref_route_supply;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Bus steps
  sequence s_setup;
    clk_en && psel && !penable && !pready;
  endsequence
  sequence s_read_hit;
    s_setup ##0 !pwrite && addr_hit;
  endsequence

  // Setups 1 and 7 leave reset at their default
  AST_RESET_VALUE: assert property ($past(!reset_n) |->
    setup_val[1] == `SCB_SETUP_RESET && setup_val[7] == `SCB_SETUP_RESET)
    else $error("setup not at reset value");
  // Read returns the stored word in the next cycle
  AST_READ_DATA: assert property (s_read_hit |=> pready && !pslverr &&
    prdata == {16'h0000, $past(setup_val[addr_setup])})
    else $error("read data wrong");
  // Unmapped address errors
  AST_UNMAPPED: assert property (s_setup ##0 !addr_hit |=> pready && pslverr)
    else $error("unmapped access not refused");
  // Coding output follows the active setup
  AST_CODING: assert property (clk_en |=>
    output_coding_select == $past(sel_val[`SCB_BIT_CODING]))
    else $error("coding select mismatch");
  // Negative input buffer follows its bit
  AST_IN_NEG: assert property (clk_en |=>
    input_neg_buffer_enable == $past(sel_val[`SCB_BIT_IN_NEG]))
    else $error("input neg buffer mismatch");
  // Reference buffers follow their bits
  AST_REF_BUF: assert property (clk_en |=>
    ref_pos_buffer_enable == $past(sel_val[`SCB_BIT_REF_POS]) &&
    ref_neg_buffer_enable == $past(sel_val[`SCB_BIT_REF_NEG]))
    else $error("reference buffer mismatch");
  // Source and sink paired with the open-wire bit
  AST_OPEN_WIRE: assert property (clk_en |=>
    open_wire_source_on == open_wire_sink_on &&
    open_wire_source_on == $past(sel_val[`SCB_BIT_OPEN_WIRE]))
    else $error("open-wire currents mismatch");
  // Route is one-hot and the supply route matches code 11
  AST_ROUTE: assert property ($onehot({ref_route_primary, ref_route_second,
    ref_route_supply}) && (ref_route_supply == (reference_source_select == 2'h3)))
    else $error("reference route wrong");
  // Reserved code keeps the primary route
  AST_REF_RESERVED: assert property (reference_source_select == 2'h2 |->
    ref_route_primary)
    else $error("reserved code not primary");
endmodule // scb_config_bank
`default_nettype wire

// file: hdl/scb_setup_reg.sv
// One 16-bit setup configuration register with byte-lane writes
`timescale 1ns/100ps
`default_nettype none
`include "scb_consts.svh"
module scb_setup_reg
  import scb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [1:0] wr_strb,
  input wire logic [`SCB_REG_W-1:0] wr_data,
  output logic [`SCB_REG_W-1:0] value
);
  // Writable bits, split per byte lane so each lane gets its own half
  localparam logic [`SCB_REG_W-1:0] wr_mask = `SCB_SETUP_WMASK;
  // Register state and its next value
  scb_setup_s st;
  scb_setup_s next_st;

  // Lane-wise masked update; reserved bits never store a one
  always_comb begin
    next_st = st;
    if (clk_en && wr_en) begin
      if (wr_strb[0]) begin
        next_st.value[7:0] = wr_data[7:0] & wr_mask[7:0];
      end
      if (wr_strb[1]) begin
        next_st.value[15:8] = wr_data[15:8] & wr_mask[15:8];
      end
    end
  end

  // State register; reset loads the documented default
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{value: `SCB_SETUP_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign value = st.value;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Full-word write lands exactly, masked
  sequence s_full_write;
    clk_en && wr_en && (wr_strb == 2'h3);
  endsequence
  AST_FULL_WRITE: assert property (s_full_write |=>
    value == ($past(wr_data) & `SCB_SETUP_WMASK))
    else $error("setup write not stored");
  // Reserved bits always zero
  AST_RESERVED_ZERO: assert property ((value & ~`SCB_SETUP_WMASK) == 16'h0000)
    else $error("reserved setup bit set");
  // Frozen while enable is low
  AST_FROZEN: assert property (!clk_en |=> $stable(value))
    else $error("setup changed while frozen");
endmodule // scb_setup_reg
`default_nettype wire

// file: shared/scb_consts.svh
// Constants for the setup configuration register bank
`ifndef SCB_CONSTS_SVH
`define SCB_CONSTS_SVH
// Number of setups held in the bank
`define SCB_NUM_SETUPS 8
// Bus widths
`define SCB_PADDR_W 12
`define SCB_DATA_W 32
`define SCB_REG_W 16
// Register indices; byte address is four times the index
`define SCB_SETUP0_IDX 10'h020
`define SCB_SETUP1_IDX 10'h021
`define SCB_SETUP2_IDX 10'h022
`define SCB_SETUP3_IDX 10'h023
`define SCB_SETUP4_IDX 10'h024
`define SCB_SETUP5_IDX 10'h025
`define SCB_SETUP6_IDX 10'h026
`define SCB_SETUP7_IDX 10'h027
// Reset value of every setup register
`define SCB_SETUP_RESET 16'h1000
// Writable bits; reserved bits 15:13, 6 and 3:0 stay zero
`define SCB_SETUP_WMASK 16'h1FB0
// Field positions
`define SCB_BIT_CODING 12
`define SCB_BIT_REF_POS 11
`define SCB_BIT_REF_NEG 10
`define SCB_BIT_IN_POS 9
`define SCB_BIT_IN_NEG 8
`define SCB_BIT_OPEN_WIRE 7
`define SCB_REF_SEL_HI 5
`define SCB_REF_SEL_LO 4
// Reference select codes
`define SCB_REF_CODE_PRIMARY 2'h0
`define SCB_REF_CODE_SECOND 2'h1
`define SCB_REF_CODE_SUPPLY 2'h3
`endif

// file: shared/scb_pkg.sv
// Types for the setup configuration register bank
`default_nettype none
`include "scb_consts.svh"
package scb_pkg;
  // Decoded reference source
  typedef enum logic [1:0] {SCB_REF_PRIMARY, SCB_REF_SECOND, SCB_REF_SUPPLY} scb_ref_e;
  // State of one setup register
  typedef struct packed {
    logic [`SCB_REG_W-1:0] value;
  } scb_setup_s;
  // State of the bank top: bus answer and decoded active setup
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [`SCB_DATA_W-1:0] prdata;
    logic output_coding_select;
    logic ref_pos_buffer_enable;
    logic ref_neg_buffer_enable;
    logic input_pos_buffer_enable;
    logic input_neg_buffer_enable;
    logic open_wire_source_on;
    logic open_wire_sink_on;
    logic [1:0] reference_source_select;
    logic ref_route_primary;
    logic ref_route_second;
    logic ref_route_supply;
  } scb_bank_s;
endpackage : scb_pkg
`default_nettype wire

// file: verif/scb_config_bank_tb.sv
// Self-checking bench for the setup configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "scb_consts.svh"
module scb_config_bank_tb;
  import scb_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] active_setup = 3'h0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  wire logic [11:0] dec_out; // Decoded outputs gathered
  localparam logic [15:0] wr_mask = `SCB_SETUP_WMASK; // Writable bits per lane
  logic [32:0] exp_q[$]; // Expected {prdata, pslverr} per transfer
  logic [32:0] e;
  logic [15:0] exp_reg[8]; // Shadow of the bank
  int err_total = 0;
  int compares = 0;
  int seed = 93862;
  scb_config_bank i_scb_config_bank (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .active_setup(active_setup), .output_coding_select(dec_out[11]),
    .ref_pos_buffer_enable(dec_out[10]), .ref_neg_buffer_enable(dec_out[9]),
    .input_pos_buffer_enable(dec_out[8]), .input_neg_buffer_enable(dec_out[7]),
    .open_wire_source_on(dec_out[6]), .open_wire_sink_on(dec_out[5]),
    .reference_source_select(dec_out[4:3]), .ref_route_primary(dec_out[2]),
    .ref_route_second(dec_out[1]), .ref_route_supply(dec_out[0]));
  scb_host_model i_scb_host_model (.ref_clk(ref_clk), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  // Clock, 10 ns period
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Verdict and end of run
  task automatic summarize;
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Bus answer compare
  task automatic cmp_bus(input logic [32:0] ex, input logic [32:0] got);
    compares++;
    if (got !== ex) begin
      err_total++;
      $display("CHECK FAILED bus answer exp %h got %h", ex, got);
    end
  endtask
  // Decoded output compare
  task automatic cmp_dec(input logic [11:0] ex);
    compares++;
    if (dec_out !== ex) begin
      err_total++;
      $display("CHECK FAILED decode exp %h got %h", ex, dec_out);
    end
  endtask
  // Expected decode of one setup value; code 10 falls back to primary
  function automatic logic [11:0] dec(input logic [15:0] v);
    dec = {v[12:7], v[7], v[5:4], (v[5:4] == 2'h0 || v[5:4] == 2'h2), v[5:4] == 2'h1,
           v[5:4] == 2'h3};
  endfunction
  // Note the expected answer, then let the host run the transfer
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] ed, input logic ee);
    exp_q.push_back({ed, ee});
    i_scb_host_model.xfer(w, a, d, s);
  endtask
  // Write one setup through its byte lanes and update the shadow
  task automatic wr(input int k, input logic [15:0] v, input logic [3:0] s);
    if (s[0]) exp_reg[k][7:0] = v[7:0] & wr_mask[7:0];
    if (s[1]) exp_reg[k][15:8] = v[15:8] & wr_mask[15:8];
    acc(1'b1, 12'h080 + 12'(k * 4), {16'h0, v}, s, 32'h0, 1'b0);
  endtask
  // Read one setup back
  task automatic rd(input int k);
    acc(1'b0, 12'h080 + 12'(k * 4), 32'h0, 4'h0, {16'h0, exp_reg[k]}, 1'b0);
  endtask
  // Select a setup and look at the decoded outputs once settled
  task automatic chk(input int k);
    @(posedge ref_clk);
    active_setup <= 3'(k);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_dec(dec(exp_reg[k]));
  endtask
  // Watcher: every completed transfer takes the oldest note
  always @(posedge ref_clk) begin
    if (psel && penable && pready) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("CHECK FAILED queue exp note got none");
      end else begin
        e = exp_q.pop_front();
        cmp_bus(e, {prdata, pslverr});
      end
    end
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      exp_reg[k] = `SCB_SETUP_RESET;
      rd(k);
    end
    chk(0);
    for (int k = 1; k < 8; k++) wr(k, 16'($random(seed)), 4'h3);
    for (int k = 0; k < 8; k++) begin
      rd(k);
      chk(k);
    end
    // Every reference code, reserved one included
    for (int c = 0; c < 4; c++) begin
      wr(3, {10'h3C2, 2'(c), 4'h0}, 4'h3);
      chk(3);
    end
    // Open-wire currents pulsed on, then off again
    wr(2, 16'h1080, 4'h3);
    chk(2);
    wr(2, 16'h1000, 4'h3);
    chk(2);
    // Clock enable low freezes the decode on the old setup
    @(posedge ref_clk);
    clk_en <= 1'b0;
    active_setup <= 3'h3;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_dec(dec(exp_reg[2]));
    @(posedge ref_clk);
    clk_en <= 1'b1;
    chk(3);
    // Single lanes and no lane
    wr(5, 16'hFFFF, 4'h1);
    rd(5);
    wr(6, 16'hFFFF, 4'h2);
    rd(6);
    wr(4, 16'hFFFF, 4'h0);
    rd(4);
    // Reset in mid-run restores every default
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 8; k++) exp_reg[k] = `SCB_SETUP_RESET;
    chk(3);
    rd(5);
    // Unmapped, misaligned and out-of-range accesses
    acc(1'b0, 12'h07C, 32'h0, 4'h0, 32'h0, 1'b1);
    acc(1'b0, 12'h081, 32'h0, 4'h0, 32'h0, 1'b1);
    acc(1'b1, 12'h0A0, 32'hFFFF, 4'h3, 32'h0, 1'b1);
    rd(7);
    repeat (2) @(posedge ref_clk);
    summarize();
  end
endmodule // scb_config_bank_tb
`default_nettype wire

// file: verif/scb_host_model.sv
// Host model: APB master that writes and reads the setup bank
`timescale 1ns/100ps
`default_nettype none
`include "scb_consts.svh"
module scb_host_model (
  input wire logic ref_clk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // One transfer; held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d & {16'h0, `SCB_SETUP_WMASK};
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No wait count assumed; the bench watchdog ends a hang
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // scb_host_model
`default_nettype wire
